// file: include/fault_cfg.svh
// constants for the controller fault status manager
`ifndef FAULT_CFG_SVH
`define FAULT_CFG_SVH
`define OFS_CTRL        32'h0000_0000
`define OFS_CONDS       32'h0000_0004
`define OFS_INSTR       32'h0000_0008
`define OFS_STATUS      32'h0000_000c
`define OFS_MSG         32'h0000_0010
`define OFS_AUX         32'h0000_0014
`define CTRL_MODE_LSB   0
`define CTRL_START_BIT  2
`define CODE_NONE       8'h00
`define CODE_CYCLE      8'hf8
`define CODE_IOVER      8'he7
`define CODE_RIO0       8'hb0
`define CODE_SPECIAL    8'hd0
`define CODE_HDIO       8'h9a
`define CODE_BATT       8'hf7
`define CODE_WDOG       8'h9f
`define CODE_ALLCLEAR   8'hff
`define MODE_PROGRAM    2'h0
`define MODE_MONITOR    2'h1
`define MODE_RUN        2'h2
`define CYCLE_WARN_MS   100
`define CYCLE_FATAL_MS  130
`define CLK_MHZ         250
`define BLINK_HALF_MS   250
`endif

// file: include/fault_pkg.sv
// types for the controller fault status manager
package fault_pkg;
	typedef enum logic [1:0] {
		st_wait,
		st_run,
		st_halt
	} run_state_t;
	typedef struct packed {
		logic [3:0] unit_id;
		logic       remote_master;
		logic       batt_memory;
		logic       io_verify;
		logic       special_err;
		logic       hdio_err;
		logic       batt_low;
		logic       remote_err;
		logic       hw_fatal;
	} cond_t;
	typedef struct packed {
		logic       power;
		logic       run_lamp;
		logic       alarm;
		logic       run_out;
		logic       outputs_enable;
	} lamps_t;
endpackage

// file: core/fault_status_manager.sv
// fault classification, indicators, fault code field and message queue
`timescale 1ns/10ps
`include "fault_cfg.svh"
// How it works
// - alarm lamp steady on fatal error, blinking when only non-fatal errors exist.
// - hardware fatal, watchdog fatal or halt instruction lights alarm, halts, outputs off.
// - post instruction with nonzero code writes fault field, operation unaffected.
// - halt instruction writes its code, stops operation, turns outputs off.
// - post instruction with code 00 clears field, loads next pending code.
// - several pending messages kept; each read request shows the next one.
// - read in program mode removes the message; run or monitor never clears.
// - when nothing is stored, reads report the all-clear code.
// - during initialisation power lamp lit, run lamp and run output off.
// - waiting state with no code while the start input is inactive.
// - waiting state with no code until special units finish initialising.
// - waiting state with no code while remote unit unpowered or unterminated.
// - non-fatal errors keep running: power, run lamps and run output on.
// - user posted codes 01 to 99 are reported as non-fatal.
// - cycle time above 100 ms posts non-fatal code F8.
// - wrong registered unit table posts non-fatal code E7.
// - remote transmission error posts B0 or B1 naming the master.
// - link or special refresh error posts D0 and names the unit; restart toggle bits are only stored and read back.
// - high-density transfer error posts 9A and names the unit.
// - low or missing battery posts F7 and flags which battery.
// - fatal: power and alarm lit, run output off; power loss lights nothing.
// - detected errors of every class except hardware fatal place their code in the fault field.
// - fault field is eight bits, a two-digit code.
// - watchdog above 130 ms default declares a fatal processor error.
module fault_status_manager #(
	parameter int DEPTH       = 8,
	parameter int BLINK_HALF  = `BLINK_HALF_MS * `CLK_MHZ * 1000,
	parameter int CYCLE_WARN  = `CYCLE_WARN_MS * `CLK_MHZ * 1000,
	parameter int CYCLE_FATAL = `CYCLE_FATAL_MS * `CLK_MHZ * 1000
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// status pins from outside the clock domain
	input  wire logic        start_input,
	input  wire logic        special_units_ready,
	input  wire logic        remote_ready,
	input  wire logic        power_good,
	// watchdog cycle strobe from the sequencer, same clock
	input  wire logic        cycle_end,
	// indicators and outputs
	output fault_pkg::lamps_t lamps,
	output logic [7:0]       fault_code
);
	localparam int AW = $clog2(DEPTH);
	// bus capture
	logic        wr_pend;
	logic        rd_pend;
	logic [4:0]  addr_q;
	logic [1:0]  mode;
	logic [3:0]  restart_toggle;
	fault_pkg::cond_t conds;
	fault_pkg::run_state_t state;
	// synchronisers
	logic [3:0]  sync1;
	logic [3:0]  sync2;
	// queue
	logic [7:0]  queue [DEPTH];
	logic [AW-1:0] rd_ptr;
	logic [AW-1:0] wr_ptr;
	logic [AW:0] count;
	logic [7:0]  msg_shown;
	// timers
	logic [31:0] cycle_cnt;
	logic [31:0] blink_cnt;
	logic        blink;
	logic        cycle_over;
	logic        wdog_fatal;
	logic [7:0]  prev_evt;
	// event posting
	logic        push;
	logic [7:0]  push_code;
	logic        pop_prog;
	logic        pop_clr;
	logic        instr_wr;
	logic [7:0]  instr_code;
	logic        instr_halt;
	logic        fatal;
	logic        nonfatal;
	logic [7:0]  evt_now;
	logic [7:0]  evt_rise;
	logic        do_push;
	logic        do_pop;
	logic [AW:0] next_count;
	logic [7:0]  next_msg_shown;
	logic [31:0] next_hrdata;
	// zero wait states and always okay, still held in flops so every output is registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			addr_q  <= 5'h00;
		end else if (hready) begin
			wr_pend <= hsel && htrans[1] && hwrite;
			rd_pend <= hsel && htrans[1] && !hwrite;
			addr_q  <= haddr[4:0];
		end
	end
	// two flops before any logic reads the pins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
		end else begin
			sync1 <= {power_good, remote_ready, special_units_ready, start_input};
			sync2 <= sync1;
		end
	end
	assign instr_wr   = wr_pend && addr_q == `OFS_INSTR;
	assign instr_code = hwdata[7:0];
	assign instr_halt = hwdata[8];
	assign pop_prog   = rd_pend && addr_q == `OFS_MSG && mode == `MODE_PROGRAM && count != '0;
	assign pop_clr    = instr_wr && !instr_halt && instr_code == `CODE_NONE && count != '0;
	// software control writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode           <= `MODE_PROGRAM;
			conds          <= '0;
			restart_toggle <= 4'h0;
		end else begin
			if (wr_pend && addr_q == `OFS_CTRL) begin
				mode           <= hwdata[1:0];
				restart_toggle <= hwdata[11:8];
			end
			if (wr_pend && addr_q == `OFS_CONDS)
				conds <= hwdata[$bits(fault_pkg::cond_t)-1:0];
		end
	end
	// cycle watchdog: warn at 100 ms, fatal at 130 ms
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cycle_cnt <= '0;
		else if (state == fault_pkg::st_run)
			cycle_cnt <= cycle_end ? '0 : cycle_cnt + 32'h1;
		else
			cycle_cnt <= '0;
	end
	// fatal flag drops outside run, else a restart from program mode would halt at once
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cycle_over <= 1'b0;
			wdog_fatal <= 1'b0;
		end else if (state == fault_pkg::st_run) begin
			if (cycle_end && cycle_cnt > CYCLE_WARN)
				cycle_over <= 1'b1;
			if (cycle_cnt > CYCLE_FATAL)
				wdog_fatal <= 1'b1;
		end else begin
			wdog_fatal <= 1'b0;
		end
	end
	// non-fatal condition events, posted once on rising
	assign evt_now = {4'h0, conds.io_verify, conds.special_err, conds.hdio_err, conds.batt_low}
		| {3'h0, conds.remote_err, 4'h0};
	assign evt_rise = evt_now & ~prev_evt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			prev_evt <= 8'h00;
		else
			prev_evt <= (state == fault_pkg::st_run) ? evt_now : prev_evt;
	end
	always_comb begin
		push      = 1'b0;
		push_code = `CODE_NONE;
		if (instr_wr && instr_code != `CODE_NONE) begin
			push      = 1'b1;
			push_code = instr_code;
		end else if (state == fault_pkg::st_run) begin
			if (wdog_fatal && !fatal) begin
				push      = 1'b1;
				push_code = `CODE_WDOG;
			end else if (cycle_end && cycle_cnt > CYCLE_WARN) begin
				push      = 1'b1;
				push_code = `CODE_CYCLE;
			end else if (evt_rise[4]) begin
				push      = 1'b1;
				push_code = `CODE_RIO0 | {7'h00, conds.remote_master};
			end else if (evt_rise[3]) begin
				push      = 1'b1;
				push_code = `CODE_IOVER;
			end else if (evt_rise[2]) begin
				push      = 1'b1;
				push_code = `CODE_SPECIAL;
			end else if (evt_rise[1]) begin
				push      = 1'b1;
				push_code = `CODE_HDIO;
			end else if (evt_rise[0]) begin
				push      = 1'b1;
				push_code = `CODE_BATT;
			end
		end
	end
	// pending message queue; full queue drops new codes
	assign do_push = push && count != DEPTH[AW:0];
	assign do_pop  = pop_prog || pop_clr;
	always_comb begin
		next_count = count;
		if (do_push && !do_pop)
			next_count = count + 1'b1;
		else if (do_pop && !do_push)
			next_count = count - 1'b1;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_push)
				wr_ptr <= wr_ptr + 1'b1;
			if (do_pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= next_count;
		end
	end
	always_ff @(posedge hclk) begin
		if (do_push)
			queue[wr_ptr] <= push_code;
	end
	// run/monitor reads walk the queue without removing; a pop moves the head, so restart the walk
	always_comb begin
		next_msg_shown = msg_shown;
		if (do_pop || count == '0)
			next_msg_shown = 8'h00;
		else if (rd_pend && addr_q == `OFS_MSG && mode != `MODE_PROGRAM) begin
			if (msg_shown + 8'h01 >= {{(7-AW){1'b0}}, count})
				next_msg_shown = 8'h00;
			else
				next_msg_shown = msg_shown + 8'h01;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			msg_shown <= 8'h00;
		else
			msg_shown <= next_msg_shown;
	end
	// operating state
	assign fatal    = state == fault_pkg::st_halt;
	assign nonfatal = count != '0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= fault_pkg::st_wait;
		end else begin
			case (state)
				fault_pkg::st_wait: begin
					if (sync2[0] && sync2[1] && sync2[2] && mode != `MODE_PROGRAM)
						state <= fault_pkg::st_run;
				end
				fault_pkg::st_run: begin
					if (conds.hw_fatal || wdog_fatal || (instr_wr && instr_halt))
						state <= fault_pkg::st_halt;
					else if (mode == `MODE_PROGRAM)
						state <= fault_pkg::st_wait;
				end
				fault_pkg::st_halt: begin
					if (mode == `MODE_PROGRAM && !conds.hw_fatal)
						state <= fault_pkg::st_wait;
				end
				default: state <= fault_pkg::st_wait;
			endcase
		end
	end
	// blink divider
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			blink_cnt <= '0;
			blink     <= 1'b0;
		end else if (blink_cnt >= BLINK_HALF - 1) begin
			blink_cnt <= '0;
			blink     <= ~blink;
		end else begin
			blink_cnt <= blink_cnt + 32'h1;
		end
	end
	// indicators, all registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lamps <= '0;
		end else if (!sync2[3]) begin
			lamps <= '0;
		end else begin
			lamps.power          <= 1'b1;
			lamps.run_lamp       <= state == fault_pkg::st_run;
			lamps.run_out        <= state == fault_pkg::st_run;
			lamps.outputs_enable <= state == fault_pkg::st_run;
			lamps.alarm          <= fatal ? 1'b1 : (nonfatal && blink);
		end
	end
	// fault code field shows head of queue
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			fault_code <= `CODE_NONE;
		else if (state == fault_pkg::st_wait && count == '0)
			fault_code <= `CODE_NONE;
		else
			fault_code <= (count != '0) ? queue[rd_ptr] : `CODE_NONE;
	end
	// read data, decoded in the address phase so it stands through the data phase
	always_comb begin
		next_hrdata = {24'h00_0000, fault_code};
		case (haddr[4:0])
			`OFS_CTRL:   next_hrdata = {20'h0_0000, restart_toggle, 6'h00, mode};
			`OFS_CONDS:  next_hrdata = {{(32-$bits(fault_pkg::cond_t)){1'b0}}, conds};
			`OFS_STATUS: next_hrdata = {16'h0000, lamps, 2'h0, cycle_over, count[3:0], 2'h0, state};
			`OFS_MSG:    next_hrdata = {24'h00_0000, (count == '0) ? `CODE_ALLCLEAR
				: queue[rd_ptr + msg_shown[AW-1:0]]};
			`OFS_AUX:    next_hrdata = {24'h00_0000, conds.unit_id, conds.remote_master, conds.batt_memory, 2'h0};
			default:     next_hrdata = {24'h00_0000, fault_code};
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (hsel && htrans[1] && !hwrite && hready)
			hrdata <= next_hrdata;
	end
endmodule

// file: bench/status_plant.sv
// sequencer model that ends each program cycle with a one-cycle strobe
`timescale 1ns/10ps
module status_plant (
	// clock
	input  wire logic       hclk,
	// cycle length in clocks, zero stops the strobe
	input  wire logic [7:0] period,
	// strobe to the block
	output logic            cycle_end
);
	logic [7:0] cnt = 8'h00;
	initial cycle_end = 1'b0;
	always @(posedge hclk) begin
		cnt <= (cnt + 8'h01 >= period) ? 8'h00 : cnt + 8'h01;
		cycle_end <= period != 8'h00 && cnt + 8'h01 >= period;
	end
endmodule

// file: bench/fault_status_monitor.sv
// assertions on the fault status manager ports
`timescale 1ns/10ps
`include "fault_cfg.svh"
module fault_status_monitor #(
	parameter int BLINK_HALF  = 8,
	parameter int CYCLE_FATAL = 30
) (
	// clock and reset
	input wire logic              hclk,
	input wire logic              hresetn,
	// bus
	input wire logic              hsel,
	input wire logic [31:0]       haddr,
	input wire logic [1:0]        htrans,
	input wire logic              hwrite,
	input wire logic              hready,
	input wire logic [31:0]       hwdata,
	// status
	input wire logic              power_good,
	input wire logic              cycle_end,
	input wire fault_pkg::lamps_t lamps,
	input wire logic [7:0]        fault_code
);
	localparam int BLINK_MAX = BLINK_HALF + 2;
	logic wr_instr;
	int   cyc;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wr_instr <= 1'b0;
		else
			wr_instr <= hsel && htrans[1] && hready && hwrite && haddr == `OFS_INSTR;
	end
	// cycles spent running since the last strobe
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cyc <= 0;
		else if (cycle_end || !lamps.run_out)
			cyc <= 0;
		else
			cyc <= cyc + 1;
	end
	fatal_outputs_off_a: assert property (lamps.alarm && !lamps.run_out |-> lamps.power && !lamps.outputs_enable)
		else $error("fatal lamps wrong");
	run_lamps_a: assert property (lamps.run_out |-> lamps.power && lamps.run_lamp && lamps.outputs_enable)
		else $error("run lamps wrong");
	power_loss_a: assert property (!power_good [*5] |-> lamps == '0)
		else $error("lamps lit without power");
	blink_toggle_a: assert property ($rose(lamps.alarm) && lamps.run_out |-> ##[1:BLINK_MAX] (!lamps.alarm || !lamps.run_out))
		else $error("alarm not blinking");
	fatal_steady_a: assert property (wr_instr && hwdata[8] && lamps.run_out |-> ##2 lamps.alarm [*8])
		else $error("fatal alarm not steady");
	watchdog_fatal_a: assert property (lamps.run_out |-> cyc <= CYCLE_FATAL + 4)
		else $error("overlong cycle kept running");
	post_keeps_run_a: assert property (wr_instr && !hwdata[8] && lamps.run_out |-> ##2 lamps.run_out)
		else $error("post stopped operation");
	halt_instr_a: assert property (wr_instr && hwdata[8] && lamps.run_out |-> ##[1:4] (lamps.alarm && !lamps.outputs_enable))
		else $error("halt did not stop");
	code_posted_a: assert property (wr_instr && hwdata[7:0] != 8'h00 && fault_code == 8'h00 && lamps.run_out
		|-> ##[1:3] fault_code != 8'h00)
		else $error("code not posted");
	cover property (wr_instr && hwdata[8]);
	cover property ($rose(lamps.alarm) && lamps.run_out);
	cover property (!power_good [*5]);
endmodule
bind fault_status_manager fault_status_monitor #(.BLINK_HALF(BLINK_HALF), .CYCLE_FATAL(CYCLE_FATAL)) mon (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .power_good, .cycle_end, .lamps,
	.fault_code);

// file: bench/tb_top.sv
// self-checking bench for the fault status manager
`timescale 1ns/10ps
`include "fault_cfg.svh"
module tb_top;
	logic              hclk = 1'b0;
	logic              hresetn = 1'b0;
	logic              hsel = 1'b0;
	logic [31:0]       haddr = 32'h0;
	logic [1:0]        htrans = 2'h0;
	logic              hwrite = 1'b0;
	logic [31:0]       hwdata = 32'h0;
	logic [31:0]       hrdata;
	logic              hreadyout;
	logic              hresp;
	logic              start_input = 1'b0;
	logic              special_units_ready = 1'b0;
	logic              remote_ready = 1'b0;
	logic              power_good = 1'b1;
	logic              cycle_end;
	logic [7:0]        period = 8'h0a;
	fault_pkg::lamps_t lamps;
	logic [7:0]        fault_code;
	logic [31:0]       rd;
	int                failures = 0;
	int                checks = 0;
	// short counts keep blink and watchdog within a few dozen clocks
	fault_status_manager #(.BLINK_HALF(8), .CYCLE_WARN(20), .CYCLE_FATAL(30)) uut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata,
		.hreadyout, .hresp, .start_input, .special_units_ready, .remote_ready, .power_good, .cycle_end, .lamps,
		.fault_code);
	status_plant plant (.hclk, .period, .cycle_end);
	initial begin
		forever #2 hclk = ~hclk;
	end
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic pause(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task automatic watch_alarm(output logic [1:0] seen);
		seen = 2'b00;
		repeat (24) begin
			@(posedge hclk);
			seen |= {lamps.alarm, ~lamps.alarm};
		end
	endtask
	// reset, then start input and then special units ready raised in turn must keep the block waiting until remote ready
	task automatic go();
		hresetn <= 1'b0;
		start_input <= 1'b0;
		special_units_ready <= 1'b0;
		remote_ready <= 1'b0;
		period <= 8'h0a;
		pause(20);
		hresetn <= 1'b1;
		pause(1);
		xfer(`OFS_CTRL, 1'b1, 32'(`MODE_RUN));
		pause(6);
		chk("wait lamps", {lamps.power, lamps.run_lamp, lamps.run_out}, 3'h4);
		start_input <= 1'b1;
		pause(6);
		chk("wait lamps", {lamps.power, lamps.run_lamp, lamps.run_out}, 3'h4);
		special_units_ready <= 1'b1;
		pause(6);
		chk("wait lamps", {lamps.power, lamps.run_lamp, lamps.run_out}, 3'h4);
		chk("wait code", fault_code, 8'h00);
		remote_ready <= 1'b1;
		pause(8);
		chk("run lamps", lamps, 5'h1b);
	endtask
	task automatic t_post();
		logic [1:0] seen;
		xfer(`OFS_INSTR, 1'b1, 32'h12);
		xfer(`OFS_INSTR, 1'b1, 32'h99);
		pause(3);
		chk("posted code", fault_code, 8'h12);
		watch_alarm(seen);
		chk("alarm blink", seen, 2'b11);
		chk("run out", lamps.run_out, 1'b1);
		xfer(`OFS_INSTR, 1'b1, 32'h0);
		pause(3);
		chk("next code", fault_code, 8'h99);
		xfer(`OFS_INSTR, 1'b1, 32'h0);
		pause(3);
		chk("cleared code", fault_code, 8'h00);
	endtask
	task automatic t_conds();
		logic [31:0] cond [6] = '{32'h2, 32'h82, 32'h4, 32'h8, 32'h10, 32'h20};
		logic [7:0]  code [6] = '{8'hb0, 8'hb1, 8'hf7, 8'h9a, 8'hd0, 8'he7};
		for (int i = 0; i < 6; i++) begin
			xfer(`OFS_CONDS, 1'b1, cond[i]);
			xfer(`OFS_CONDS, 1'b1, 32'h0);
			pause(3);
			chk("event code", fault_code, code[i]);
			xfer(`OFS_INSTR, 1'b1, 32'h0);
		end
		period <= 8'h18;
		pause(60);
		chk("overrun code", fault_code, 8'hf8);
		chk("overrun run", lamps.run_out, 1'b1);
	endtask
	// monitor mode only presents, program mode also removes
	task automatic t_msgs(input logic prog);
		logic [7:0] exp [3] = '{8'h21, 8'h22, 8'hff};
		xfer(`OFS_INSTR, 1'b1, 32'h21);
		xfer(`OFS_INSTR, 1'b1, 32'h22);
		xfer(`OFS_CTRL, 1'b1, prog ? 32'(`MODE_PROGRAM) : 32'(`MODE_MONITOR));
		for (int i = 0; i < 2 + prog; i++) begin
			xfer(`OFS_MSG, 1'b0, 32'h0);
			chk("message", rd[7:0], exp[i]);
		end
		pause(3);
		chk("head after reads", fault_code, prog ? 8'h00 : 8'h21);
	endtask
	task automatic t_fatal(input logic instr);
		logic [1:0] seen;
		if (instr)
			xfer(`OFS_INSTR, 1'b1, 32'h155);
		else
			xfer(`OFS_CONDS, 1'b1, 32'h344);
		xfer(`OFS_CONDS, 1'b1, instr ? 32'h0 : 32'h345);
		pause(3);
		chk("fatal lamps", {lamps.power, lamps.alarm, lamps.run_out, lamps.outputs_enable}, 4'hc);
		chk("fatal code", fault_code, instr ? 8'h55 : 8'hf7);
		watch_alarm(seen);
		chk("steady alarm", seen, 2'b10);
		xfer(`OFS_AUX, 1'b0, 32'h0);
		chk("battery flags", rd, instr ? 32'h00 : 32'h34);
		xfer(`OFS_STATUS, 1'b0, 32'h0);
		chk("halt status", rd, 32'h0000_a012);
	endtask
	task automatic report_and_stop();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		go();
		t_post();
		t_conds();
		go();
		t_msgs(1'b0);
		go();
		t_msgs(1'b1);
		go();
		t_fatal(1'b1);
		go();
		t_fatal(1'b0);
		go();
		period <= 8'h00;
		pause(50);
		chk("watchdog code", fault_code, `CODE_WDOG);
		chk("watchdog out", lamps.run_out, 1'b0);
		power_good <= 1'b0;
		pause(6);
		chk("power loss", lamps, 5'h00);
		report_and_stop();
	end
	// the whole run needs well under this many clocks
	initial begin
		pause(20000);
		failures++;
		report_and_stop();
	end
endmodule
